//--- hdl/synth_pkg.sv
// Constants shared by the synthesizer serial load and divider logic.
`default_nettype none
package synth_pkg;
   // ----------------------------------------------------------------
   // Serial word and latch selection
   // ----------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam int CODE_W = 3;
   localparam int NUM_LATCH = 7;
   localparam logic [2:0] LATCH_RF_N = 3'h0;
   localparam logic [2:0] LATCH_RF_R = 3'h1;
   localparam logic [2:0] LATCH_RF_CTL = 3'h2;
   localparam logic [2:0] LATCH_MASTER = 3'h3;
   localparam logic [2:0] LATCH_IF_N = 3'h4;
   localparam logic [2:0] LATCH_IF_R = 3'h5;
   localparam logic [2:0] LATCH_IF_CTL = 3'h6;
   localparam logic [2:0] LATCH_NONE = 3'h7;
   localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
   // ----------------------------------------------------------------
   // Field positions inside the latches
   // ----------------------------------------------------------------
   localparam int RF_INT_LSB = 15;
   localparam int RF_FRAC_LSB = 3;
   localparam int RF_MOD_LSB = 3;
   localparam int RF_R_LSB = 15;
   localparam int RF_DOUBLER_BIT = 19;
   localparam int MON_SEL_LSB = 7;
   localparam int IF_A_LSB = 3;
   localparam int IF_B_LSB = 9;
   localparam int IF_PRE_LSB = 21;
   localparam int IF_R_LSB = 3;
   // ----------------------------------------------------------------
   // Divider limits
   // ----------------------------------------------------------------
   localparam logic [8:0] RF_INT_MIN = 9'h01f;
   localparam logic [11:0] RF_MOD_MIN = 12'h002;
   localparam logic [11:0] IF_B_MIN = 12'h003;
   localparam logic [6:0] IF_PRE_BASE = 7'h08;
   // ----------------------------------------------------------------
   // Register port map and status bits
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MASK = 8'h04;
   localparam logic [7:0] REG_STATE = 8'h08;
   localparam logic [7:0] REG_LATCH0 = 8'h20;
   localparam int EV_W = 6;
   localparam int EV_LOADED = 0;
   localparam int EV_RF_LOCK = 1;
   localparam int EV_RF_LOSS = 2;
   localparam int EV_IF_LOCK = 3;
   localparam int EV_IF_LOSS = 4;
   localparam int EV_DISCARD = 5;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int MCLK_PERIOD_NS = 25;
   localparam int ABL_TIME_NS = 50;
   localparam int ABL_CYCLES = (ABL_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int LOCK_WIN_NS = 100;
   localparam int LOCK_WIN_CYCLES = LOCK_WIN_NS / MCLK_PERIOD_NS;
   localparam int LOCK_COUNT = 5;
   // ----------------------------------------------------------------
   // Monitor pin selections
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MON_OFF = 4'h0,
      MON_RF_LOCK = 4'h1,
      MON_IF_LOCK = 4'h2,
      MON_BOTH_LOCK = 4'h3,
      MON_RF_REF = 4'h4,
      MON_RF_FB = 4'h5,
      MON_IF_REF = 4'h6,
      MON_IF_FB = 4'h7,
      MON_RF_ALOCK = 4'h8,
      MON_IF_ALOCK = 4'h9
   } mon_sel_t;
endpackage
`default_nettype wire

//--- hdl/synth_serial_load_and_dividers.sv
// Serial load port, divider chains, phase detectors and monitor output.
//
// Strobed register access and the address map were decided locally.
`default_nettype none
module synth_serial_load_and_dividers import synth_pkg::*; #(
   parameter int LOCK_CNT = LOCK_COUNT
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Serial programming pins
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic latch_strobe,
   // Reference and VCO inputs
   input wire logic reference_input,
   input wire logic rf_input,
   input wire logic if_input,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Phase detector outputs, index 0 is RF and 1 is IF
   output logic [1:0] pump_up,
   output logic [1:0] pump_down,
   // Monitor pin and interrupt
   output logic monitor_output_o,
   output logic monitor_output_oe,
   output logic irq
);
   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [5:0] pin_meta, pin_sync, pin_prev;
   logic sclk_rise, le_rise, ref_rise, ref_fall, rf_rise, if_rise, sdata_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
         pin_prev <= 6'h00;
      end else if (ce) begin
         pin_meta <= {if_input, rf_input, reference_input, latch_strobe, serial_data, serial_clock};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end
   assign sclk_rise = pin_sync[0] & ~pin_prev[0];
   assign sdata_q = pin_sync[1];
   assign le_rise = pin_sync[2] & ~pin_prev[2];
   assign ref_rise = pin_sync[3] & ~pin_prev[3];
   assign ref_fall = ~pin_sync[3] & pin_prev[3];
   assign rf_rise = pin_sync[4] & ~pin_prev[4];
   assign if_rise = pin_sync[5] & ~pin_prev[5];

   // ----------------------------------------------------------------
   // Shift register and latches
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] shift;
   logic [NUM_LATCH-1:0][WORD_W-1:0] latch;
   logic loaded_ev, discard_ev;
   always_ff @(posedge mclk) begin
      if (rst) begin
         shift <= LATCH_RESET;
      end else if (ce && sclk_rise) begin
         shift <= {shift[WORD_W-2:0], sdata_q};
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         latch <= {NUM_LATCH{LATCH_RESET}};
         loaded_ev <= 1'b0;
         discard_ev <= 1'b0;
      end else if (ce) begin
         loaded_ev <= le_rise && shift[CODE_W-1:0] != LATCH_NONE;
         discard_ev <= le_rise && shift[CODE_W-1:0] == LATCH_NONE;
         if (le_rise && shift[CODE_W-1:0] != LATCH_NONE) begin
            latch[shift[CODE_W-1:0]] <= shift;
         end
      end
   end

   // ----------------------------------------------------------------
   // Field extraction with range clamping
   // ----------------------------------------------------------------
   logic [8:0] int_eff;
   logic [11:0] frac_val, mod_eff, b_eff;
   logic [3:0] rf_r;
   logic rf_dbl;
   logic [14:0] if_r;
   logic [5:0] a_val;
   logic [6:0] pre_p;
   logic [3:0] mon_sel;
   always_comb begin
      int_eff = {1'b0, latch[LATCH_RF_N][RF_INT_LSB +: 8]};
      if (int_eff < RF_INT_MIN) int_eff = RF_INT_MIN;
      frac_val = latch[LATCH_RF_N][RF_FRAC_LSB +: 12];
      mod_eff = latch[LATCH_RF_R][RF_MOD_LSB +: 12];
      if (mod_eff < RF_MOD_MIN) mod_eff = RF_MOD_MIN;
      if (frac_val >= mod_eff) frac_val = mod_eff - 12'h001;
      rf_r = latch[LATCH_RF_R][RF_R_LSB +: 4];
      rf_dbl = latch[LATCH_RF_R][RF_DOUBLER_BIT];
      if_r = latch[LATCH_IF_R][IF_R_LSB +: 15];
      a_val = latch[LATCH_IF_N][IF_A_LSB +: 6];
      b_eff = latch[LATCH_IF_N][IF_B_LSB +: 12];
      if (b_eff < IF_B_MIN) b_eff = IF_B_MIN;
      pre_p = IF_PRE_BASE << latch[LATCH_IF_N][IF_PRE_LSB +: 2];
      mon_sel = latch[LATCH_MASTER][MON_SEL_LSB +: 4];
   end

   // ----------------------------------------------------------------
   // Reference dividers
   // ----------------------------------------------------------------
   logic rf_ref_evt;
   logic [3:0] rr_cnt;
   logic [14:0] ir_cnt;
   logic [1:0] ref_p, fb_p;
   assign rf_ref_evt = ref_rise | (rf_dbl & ref_fall);
   always_ff @(posedge mclk) begin
      if (rst) begin
         rr_cnt <= 4'h0;
         ref_p[0] <= 1'b0;
      end else if (ce) begin
         ref_p[0] <= 1'b0;
         if (rf_ref_evt) begin
            if (rr_cnt + 4'h1 >= rf_r) begin
               rr_cnt <= 4'h0;
               ref_p[0] <= 1'b1;
            end else begin
               rr_cnt <= rr_cnt + 4'h1;
            end
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         ir_cnt <= 15'h0000;
         ref_p[1] <= 1'b0;
      end else if (ce) begin
         ref_p[1] <= 1'b0;
         if (ref_rise) begin
            if (ir_cnt + 15'h0001 >= if_r) begin
               ir_cnt <= 15'h0000;
               ref_p[1] <= 1'b1;
            end else begin
               ir_cnt <= ir_cnt + 15'h0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // RF fractional feedback divider
   // ----------------------------------------------------------------
   logic [8:0] nf_cnt, rf_div;
   logic [11:0] frac_acc;
   logic [12:0] frac_sum;
   assign frac_sum = {1'b0, frac_acc} + {1'b0, frac_val};
   always_ff @(posedge mclk) begin
      if (rst) begin
         nf_cnt <= 9'h000;
         rf_div <= RF_INT_MIN;
         frac_acc <= 12'h000;
         fb_p[0] <= 1'b0;
      end else if (ce) begin
         fb_p[0] <= 1'b0;
         if (rf_rise) begin
            if (nf_cnt + 9'h001 >= rf_div) begin
               nf_cnt <= 9'h000;
               fb_p[0] <= 1'b1;
               // One extra count whenever the accumulator overflows the modulus.
               if (frac_sum >= {1'b0, mod_eff}) begin
                  frac_acc <= 12'(frac_sum - {1'b0, mod_eff});
                  rf_div <= int_eff + 9'h001;
               end else begin
                  frac_acc <= frac_sum[11:0];
                  rf_div <= int_eff;
               end
            end else begin
               nf_cnt <= nf_cnt + 9'h001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // IF pulse swallow divider
   // ----------------------------------------------------------------
   logic [6:0] pre_cnt, pre_mod;
   logic [11:0] b_left;
   logic [5:0] a_left;
   assign pre_mod = (a_left != 6'h00) ? pre_p + 7'h01 : pre_p;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_cnt <= 7'h00;
         b_left <= 12'h000;
         a_left <= 6'h00;
         fb_p[1] <= 1'b0;
      end else if (ce) begin
         fb_p[1] <= 1'b0;
         if (if_rise) begin
            if (pre_cnt + 7'h01 >= pre_mod) begin
               pre_cnt <= 7'h00;
               if (b_left <= 12'h001) begin
                  b_left <= b_eff;
                  a_left <= a_val;
                  fb_p[1] <= 1'b1;
               end else begin
                  b_left <= b_left - 12'h001;
                  if (a_left != 6'h00) a_left <= a_left - 6'h01;
               end
            end else begin
               pre_cnt <= pre_cnt + 7'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Phase detectors and lock detect
   // ----------------------------------------------------------------
   logic [1:0] locked, fb_half, ref_half;
   for (genvar c = 0; c < 2; c++) begin : g_pfd
      logic [1:0] abl_cnt;
      logic [15:0] err_cnt;
      logic [3:0] good_cnt;
      always_ff @(posedge mclk) begin
         if (rst) begin
            pump_up[c] <= 1'b0;
            pump_down[c] <= 1'b0;
            abl_cnt <= 2'h0;
         end else if (ce) begin
            if (pump_up[c] && pump_down[c]) begin
               // Both sides stay on for the antibacklash time before reset.
               if (abl_cnt == 2'(ABL_CYCLES - 1)) begin
                  abl_cnt <= 2'h0;
                  pump_up[c] <= ref_p[c];
                  pump_down[c] <= fb_p[c];
               end else begin
                  abl_cnt <= abl_cnt + 2'h1;
               end
            end else begin
               if (ref_p[c]) pump_up[c] <= 1'b1;
               if (fb_p[c]) pump_down[c] <= 1'b1;
            end
         end
      end
      always_ff @(posedge mclk) begin
         if (rst) begin
            err_cnt <= 16'h0000;
            good_cnt <= 4'h0;
            locked[c] <= 1'b0;
            fb_half[c] <= 1'b0;
            ref_half[c] <= 1'b0;
         end else if (ce) begin
            if (fb_p[c]) fb_half[c] <= ~fb_half[c];
            if (ref_p[c]) ref_half[c] <= ~ref_half[c];
            if (pump_up[c] && pump_down[c] && abl_cnt == 2'h0) begin
               err_cnt <= 16'h0000;
               if (err_cnt <= 16'(LOCK_WIN_CYCLES)) begin
                  if (good_cnt >= 4'(LOCK_CNT - 1)) locked[c] <= 1'b1;
                  else good_cnt <= good_cnt + 4'h1;
               end else begin
                  good_cnt <= 4'h0;
                  locked[c] <= 1'b0;
               end
            end else if (pump_up[c] ^ pump_down[c]) begin
               if (err_cnt != 16'hffff) err_cnt <= err_cnt + 16'h0001;
               else begin
                  good_cnt <= 4'h0;
                  locked[c] <= 1'b0;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Monitor output multiplexer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         monitor_output_o <= 1'b0;
         monitor_output_oe <= 1'b0;
      end else if (ce) begin
         monitor_output_oe <= 1'b1;
         monitor_output_o <= 1'b0;
         case (mon_sel)
            MON_OFF: monitor_output_oe <= 1'b0;
            MON_RF_LOCK: monitor_output_o <= locked[0];
            MON_IF_LOCK: monitor_output_o <= locked[1];
            MON_BOTH_LOCK: monitor_output_o <= &locked;
            MON_RF_REF: monitor_output_o <= ref_half[0];
            MON_RF_FB: monitor_output_o <= fb_half[0];
            MON_IF_REF: monitor_output_o <= ref_half[1];
            MON_IF_FB: monitor_output_o <= fb_half[1];
            // Open drain: pull low unless locked, then only during pump activity.
            MON_RF_ALOCK: monitor_output_oe <= ~locked[0] | pump_up[0] | pump_down[0];
            MON_IF_ALOCK: monitor_output_oe <= ~locked[1] | pump_up[1] | pump_down[1];
            default: monitor_output_o <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status, mask, interrupt and register port
   // ----------------------------------------------------------------
   logic [EV_W-1:0] status, mask, events;
   logic [1:0] locked_prev;
   logic [2:0] last_code;
   always_comb begin
      events = '0;
      events[EV_LOADED] = loaded_ev;
      events[EV_DISCARD] = discard_ev;
      events[EV_RF_LOCK] = locked[0] & ~locked_prev[0];
      events[EV_RF_LOSS] = ~locked[0] & locked_prev[0];
      events[EV_IF_LOCK] = locked[1] & ~locked_prev[1];
      events[EV_IF_LOSS] = ~locked[1] & locked_prev[1];
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         status <= '0;
         mask <= '0;
         locked_prev <= 2'h0;
         last_code <= 3'h0;
         irq <= 1'b0;
      end else if (ce) begin
         locked_prev <= locked;
         if (le_rise) last_code <= shift[CODE_W-1:0];
         if (wr && addr == REG_MASK) mask <= wdata[EV_W-1:0];
         // A new event wins over a write-one clear in the same cycle.
         if (wr && addr == REG_STATUS) status <= (status & ~wdata[EV_W-1:0]) | events;
         else status <= status | events;
         irq <= |(status & mask);
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (ce) begin
         rdata <= 32'h00000000;
         if (rd) begin
            if (addr == REG_STATUS) rdata <= {26'h0000000, status};
            else if (addr == REG_MASK) rdata <= {26'h0000000, mask};
            else if (addr == REG_STATE) rdata <= {21'h000000, last_code, mon_sel, 2'h0, locked};
            else if (addr >= REG_LATCH0 && addr < REG_LATCH0 + 8'h1c && addr[1:0] == 2'h0) begin
               rdata <= {8'h00, latch[3'(addr[4:2])]};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   shift_load_a: assert property (ce && sclk_rise |=> shift == {$past(shift[WORD_W-2:0]), $past(sdata_q)})
      else $error("shift register did not take the data bit");
   latch_copy_a: assert property (ce && le_rise && shift[2:0] != LATCH_NONE
      |=> latch[$past(shift[2:0])] == $past(shift))
      else $error("strobe did not copy the word");
   no_latch_a: assert property (ce && le_rise && shift[2:0] == LATCH_NONE |=> $stable(latch))
      else $error("code 111 changed a latch");
   rf_int_range_a: assert property (rf_div >= RF_INT_MIN)
      else $error("RF divide ratio below minimum");
   frac_acc_a: assert property (frac_acc < mod_eff || $changed(mod_eff) || $past(rst))
      else $error("fraction accumulator reached the modulus");
   rf_ref_div_a: assert property (ce && rf_ref_evt && rr_cnt + 4'h1 >= rf_r |=> ref_p[0] && rr_cnt == 4'h0)
      else $error("RF reference divider missed its terminal count");
   if_reload_a: assert property (ce && if_rise && pre_cnt + 7'h01 >= pre_mod && b_left <= 12'h001
      |=> fb_p[1] && a_left == $past(a_val) && b_left == $past(b_eff))
      else $error("IF counters did not reload");
   abl_width_a: assert property ($rose(pump_up[0] && pump_down[0]) ##0 ce[*2]
      |=> pump_up[0] == $past(ref_p[0]) && pump_down[0] == $past(fb_p[0]))
      else $error("antibacklash pulse too long");
   mon_dlock_a: assert property (ce && mon_sel == MON_RF_LOCK |=> monitor_output_oe && monitor_output_o == $past(locked[0]))
      else $error("digital lock not shown on monitor");
   mon_alock_a: assert property (ce && mon_sel == MON_RF_ALOCK && locked[0] && !pump_up[0] && !pump_down[0]
      |=> !monitor_output_oe)
      else $error("analog lock pulled low while quiet");
   irq_level_a: assert property ($past(ce) |-> irq == $past(|(status & mask)))
      else $error("interrupt does not follow status and mask");
   load_cov_c: cover property (ce && le_rise && shift[2:0] == LATCH_MASTER);
   discard_cov_c: cover property (discard_ev);
   rf_lock_cov_c: cover property ($rose(locked[0]));
   if_lock_cov_c: cover property ($rose(locked[1]));
endmodule
`default_nettype wire

//--- tb/serial_host.sv
// Host controller model that shifts words into the serial programming port.
`default_nettype none
module serial_host (
   // Clock
   input wire logic mclk,
   // Serial programming pins
   output logic serial_clock,
   output logic serial_data,
   output logic latch_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      serial_clock = 1'b0;
      serial_data = 1'b0;
      latch_strobe = 1'b0;
   end
   // Shifts a word out with a 200 ns serial clock that rests low between frames, then strobes it.
   task automatic send(input logic [23:0] w);
      for (int b = 23; b >= 0; b--) begin
         @(posedge mclk) serial_data <= w[b];
         repeat (3) @(posedge mclk);
         serial_clock <= 1'b1;
         repeat (4) @(posedge mclk);
         serial_clock <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      serial_data <= ~w[0];
      latch_strobe <= 1'b1;
      repeat (4) @(posedge mclk);
      latch_strobe <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the synthesizer serial load and divider block.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import synth_pkg::*;
   logic mclk, rst, wr, rd, serial_clock, serial_data, latch_strobe, monitor_output_o, monitor_output_oe, irq;
   logic ce = 1'b1;
   logic reference_input = 1'b0;
   logic rf_input = 1'b0;
   logic if_input = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rv;
   logic [1:0] pump_up, pump_down;
   logic [23:0] w;
   logic [23:0] exp_latch [7];
   int error_cnt, checks, cycles;
   synth_serial_load_and_dividers #(.LOCK_CNT(2)) synth_serial_load_and_dividers_i (.mclk(mclk), .rst(rst),
      .ce(ce), .serial_clock(serial_clock), .serial_data(serial_data), .latch_strobe(latch_strobe),
      .reference_input(reference_input), .rf_input(rf_input), .if_input(if_input), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pump_up(pump_up), .pump_down(pump_down),
      .monitor_output_o(monitor_output_o), .monitor_output_oe(monitor_output_oe), .irq(irq));
   serial_host serial_host_i (.mclk(mclk), .serial_clock(serial_clock), .serial_data(serial_data),
      .latch_strobe(latch_strobe));
   // ----------------------------------------------------------------
   // Clocks and timeout
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always begin
      repeat (4) @(posedge mclk);
      reference_input <= ~reference_input;
   end
   always begin
      repeat (2) @(posedge mclk);
      rf_input <= ~rf_input;
      if_input <= ~if_input;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk) addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk) wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk) addr <= a;
      rd <= 1'b1;
      @(posedge mclk) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
   endtask
   task automatic check_latches();
      for (int i = 0; i < NUM_LATCH; i++) begin
         rd_reg(8'(REG_LATCH0 + 4 * i), rv);
         check("latch", rv, {8'h00, exp_latch[i]});
      end
   endtask
   // Counts monitor rising edges over forty divider periods; twenty are expected.
   task automatic div_case(input string what, input logic [23:0] cw, input logic [3:0] sel, input int per);
      int cnt;
      logic prev;
      serial_host_i.send(cw);
      serial_host_i.send((24'(sel) << 7) | 24'h000003);
      rd_reg(REG_STATE, rv);
      check("monitor select", 32'(rv[7:4]), 32'(sel));
      cnt = 0;
      prev = monitor_output_o;
      repeat (40 * per) begin
         @(posedge mclk);
         #1;
         if (monitor_output_o && !prev) cnt++;
         prev = monitor_output_o;
      end
      check(what, 32'(cnt >= 19 && cnt <= 21), 32'h1);
   endtask
   // Counts IF pump rises over ten feedback periods; each feedback pulse gives one down pulse.
   task automatic pump_case();
      int ups, downs;
      logic pu, pd;
      ups = 0;
      downs = 0;
      pu = pump_up[1];
      pd = pump_down[1];
      repeat (1040) begin
         @(posedge mclk);
         #1;
         if (pump_up[1] && !pu) ups++;
         if (pump_down[1] && !pd) downs++;
         pu = pump_up[1];
         pd = pump_down[1];
      end
      check("if pump down", 32'(downs >= 9 && downs <= 11), 32'h1);
      check("if pump up", 32'(ups >= 7 && ups <= 11), 32'h1);
   endtask
   // Neither loop can lock with the ratios in use, so every lock selection drives a low level.
   task automatic mon_case(input logic [3:0] sel);
      serial_host_i.send((24'(sel) << 7) | 24'h000003);
      @(posedge mclk);
      #1;
      check("monitor enable", {31'h0, monitor_output_oe}, 32'h1);
      check("monitor level", {31'h0, monitor_output_o}, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      for (int i = 0; i < NUM_LATCH; i++) exp_latch[i] = 24'h0;
      do_reset();
      rd_reg(REG_STATUS, rv);
      check("status", rv, 32'h0);
      rd_reg(REG_MASK, rv);
      check("mask", rv, 32'h0);
      wr_reg(8'h40, 32'hffffffff);
      rd_reg(8'h40, rv);
      check("unmapped", rv, 32'h0);
      wr_reg(REG_LATCH0, 32'hffffffff);
      for (int c = 0; c < 8; c++) begin
         w = 24'h800040 | (24'(c) << 20) | (24'(c) << 11) | 24'(c);
         serial_host_i.send(w);
         if (c < NUM_LATCH) exp_latch[c] = w;
         check_latches();
         rd_reg(REG_STATE, rv);
         check("last code", 32'(rv[10:8]), 32'(c));
      end
      check("monitor off", {31'h0, monitor_output_oe}, 32'h0);
      rd_reg(REG_STATUS, rv);
      check("load events", rv & 32'h21, 32'h21);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr_reg(REG_MASK, 32'h21);
      rd_reg(REG_MASK, rv);
      check("mask", rv, 32'h21);
      check("irq", {31'h0, irq}, 32'h1);
      wr_reg(REG_STATUS, 32'h21);
      rd_reg(REG_STATUS, rv);
      check("cleared", rv & 32'h21, 32'h0);
      repeat (2) @(posedge mclk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      do_reset();
      div_case("rf ref", 24'h018011, 4'h4, 24);
      div_case("rf ref doubled", 24'h098011, 4'h4, 12);
      div_case("rf feedback", 24'h0f8000, 4'h5, 124);
      div_case("if ref", 24'h00002d, 4'h6, 40);
      div_case("if feedback", 24'h000614, 4'h7, 104);
      pump_case();
      mon_case(4'h1);
      mon_case(4'h2);
      mon_case(4'h8);
      mon_case(4'h9);
      rd_reg(REG_STATE, rv);
      check("lock state", rv & 32'h3, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
